// ===== core_option_interrupt_reset_regs.sv
// core option, interrupt and reset cause registers behind an APB slave
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
module core_option_interrupt_reset_regs
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // reset causes
  input wire logic i_power_on_reset,
  input wire logic i_brown_out_reset,
  input wire logic i_brown_out_enable,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // pins
  input wire logic i_ext_irq_pin,
  input wire logic i_timer0_clock_pin,
  input wire logic [core_regs_pkg::PORT_PINS-1:0] i_port_pins,
  // peripheral interrupt sources
  input wire logic i_peripheral_irq,
  // outputs to core and port
  output logic o_irq_request,
  output logic [core_regs_pkg::PORT_PINS-1:0] o_pullup_on,
  output logic o_wdt_tick
);
  timer0_if tif();

  logic [7:0] option_config_q;
  logic [7:0] interrupt_control_q;
  logic [1:0] reset_cause_q;
  logic [core_regs_pkg::PORT_PINS-1:0] pin_change_enable_q;
  logic [core_regs_pkg::PORT_PINS-1:0] pullup_enable_q;
  logic ext_rise;
  logic ext_fall;
  logic [core_regs_pkg::PORT_PINS-1:0] pin_rise;
  logic [core_regs_pkg::PORT_PINS-1:0] pin_fall;
  logic ext_event;
  logic pin_event;
  logic wr_access;
  logic rd_access;
  logic addr_hit;
  logic [7:0] rd_byte;
  logic irq_d;

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == core_regs_pkg::OFS_OPTION_CONFIG) || (a == core_regs_pkg::OFS_INTERRUPT_CONTROL) ||
      (a == core_regs_pkg::OFS_RESET_CAUSE_STATUS) || (a == core_regs_pkg::OFS_PIN_CHANGE_ENABLE) ||
      (a == core_regs_pkg::OFS_PULLUP_ENABLE) || (a == core_regs_pkg::OFS_TIMER0_COUNT);
  endfunction

  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] ofs, input logic wr);
    wr_to = wr && (a == ofs);
  endfunction

  // one wait state: setup, access, then ready
  assign wr_access = i_psel && i_penable && i_pwrite && o_pready;
  assign rd_access = i_psel && i_penable && !i_pwrite && !o_pready;
  assign addr_hit = is_mapped(i_paddr);

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pready <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel && i_penable && !o_pready;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pslverr <= i_psel && i_penable && !o_pready && !addr_hit;
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (i_paddr)
      core_regs_pkg::OFS_OPTION_CONFIG: rd_byte = option_config_q;
      core_regs_pkg::OFS_INTERRUPT_CONTROL: rd_byte = interrupt_control_q;
      // brown-out bit hidden while brown-out reset is off
      core_regs_pkg::OFS_RESET_CAUSE_STATUS: rd_byte = {6'h00, reset_cause_q[1], reset_cause_q[0] & i_brown_out_enable};
      core_regs_pkg::OFS_PIN_CHANGE_ENABLE: rd_byte = {2'h0, pin_change_enable_q};
      core_regs_pkg::OFS_PULLUP_ENABLE: rd_byte = {2'h0, pullup_enable_q};
      core_regs_pkg::OFS_TIMER0_COUNT: rd_byte = tif.count;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_prdata <= 32'h00000000;
    end
    else if (rd_access)
    begin
      o_prdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      option_config_q <= core_regs_pkg::RST_OPTION_CONFIG;
    end
    else if (wr_to(i_paddr, core_regs_pkg::OFS_OPTION_CONFIG, wr_access))
    begin
      option_config_q <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pin_change_enable_q <= core_regs_pkg::RST_PIN_CHANGE_ENABLE[core_regs_pkg::PORT_PINS-1:0];
    end
    else if (wr_to(i_paddr, core_regs_pkg::OFS_PIN_CHANGE_ENABLE, wr_access))
    begin
      pin_change_enable_q <= i_pwdata[core_regs_pkg::PORT_PINS-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pullup_enable_q <= core_regs_pkg::RST_PULLUP_ENABLE[core_regs_pkg::PORT_PINS-1:0];
    end
    else if (wr_to(i_paddr, core_regs_pkg::OFS_PULLUP_ENABLE, wr_access))
    begin
      pullup_enable_q <= i_pwdata[core_regs_pkg::PORT_PINS-1:0];
    end
  end

  // global disable overrides per-pin enables
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pullup_on <= '0;
    end
    else
    begin
      o_pullup_on <= option_config_q[core_regs_pkg::OPT_PULLUP_GLOBAL_DISABLE] ? '0 : pullup_enable_q;
    end
  end

  // ----------------------------------------------------------------------------
  // timer0 and prescaler
  // ----------------------------------------------------------------------------
  assign tif.source_sel = option_config_q[core_regs_pkg::OPT_TIMER0_SOURCE_SEL];
  assign tif.edge_sel = option_config_q[core_regs_pkg::OPT_TIMER0_EDGE_SEL];
  assign tif.prescaler_assign = option_config_q[core_regs_pkg::OPT_PRESCALER_ASSIGN];
  assign tif.prescaler_rate = option_config_q[2:0];
  assign tif.count_wr = wr_to(i_paddr, core_regs_pkg::OFS_TIMER0_COUNT, wr_access);
  assign tif.count_wdata = i_pwdata[7:0];

  timer0_unit u_timer0
  (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_timer0_clock_pin(i_timer0_clock_pin),
    .tif(tif)
  );

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_wdt_tick <= 1'b0;
    end
    else
    begin
      o_wdt_tick <= tif.wdt_tick;
    end
  end

  // ----------------------------------------------------------------------------
  // pin events
  // ----------------------------------------------------------------------------
  edge_detect #(.WIDTH(1)) u_ext_edge
  (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_level(i_ext_irq_pin),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  edge_detect #(.WIDTH(core_regs_pkg::PORT_PINS)) u_pin_edge
  (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_level(i_port_pins),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  assign ext_event = option_config_q[core_regs_pkg::OPT_EXT_IRQ_EDGE_SEL] ? ext_rise : ext_fall;
  assign pin_event = |((pin_rise | pin_fall) & pin_change_enable_q);

  // ----------------------------------------------------------------------------
  // interrupt control: flags set regardless of interrupt enables (pin change only on pins in pin_change_enable_q), set beats clear
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      interrupt_control_q <= core_regs_pkg::RST_INTERRUPT_CONTROL;
    end
    else
    begin
      if (wr_to(i_paddr, core_regs_pkg::OFS_INTERRUPT_CONTROL, wr_access))
      begin
        interrupt_control_q <= i_pwdata[7:0];
      end
      if (tif.overflow)
      begin
        interrupt_control_q[core_regs_pkg::IC_TIMER0_OVERFLOW_FLAG] <= 1'b1;
      end
      if (ext_event)
      begin
        interrupt_control_q[core_regs_pkg::IC_EXT_PIN_IRQ_FLAG] <= 1'b1;
      end
      if (pin_event)
      begin
        interrupt_control_q[core_regs_pkg::IC_PIN_CHANGE_FLAG] <= 1'b1;
      end
    end
  end

  always_comb
  begin
    irq_d = interrupt_control_q[core_regs_pkg::IC_GLOBAL_IRQ_ENABLE] && (
      (interrupt_control_q[5] && interrupt_control_q[2]) ||
      (interrupt_control_q[4] && interrupt_control_q[1]) ||
      (interrupt_control_q[3] && interrupt_control_q[0]) ||
      (interrupt_control_q[core_regs_pkg::IC_PERIPHERAL_IRQ_ENABLE] && i_peripheral_irq));
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_irq_request <= 1'b0;
    end
    else
    begin
      o_irq_request <= irq_d;
    end
  end

  // ----------------------------------------------------------------------------
  // reset cause: cleared by its own reset, set by software
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      reset_cause_q <= core_regs_pkg::RST_RESET_CAUSE_STATUS;
    end
    else
    begin
      if (wr_to(i_paddr, core_regs_pkg::OFS_RESET_CAUSE_STATUS, wr_access))
      begin
        reset_cause_q <= i_pwdata[1:0];
      end
      if (i_power_on_reset)
      begin
        reset_cause_q[core_regs_pkg::RCS_POWER_ON] <= 1'b0;
      end
      if (i_brown_out_reset)
      begin
        reset_cause_q[core_regs_pkg::RCS_BROWN_OUT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  property p_flag_tmr;
    @(posedge i_sys_clk) disable iff (i_sys_rst) tif.overflow |=> interrupt_control_q[2];
  endproperty
  a_flag_tmr: assert property (p_flag_tmr) else $error("timer0 overflow flag not set");

  property p_flag_ext;
    @(posedge i_sys_clk) disable iff (i_sys_rst) ext_event |=> interrupt_control_q[1];
  endproperty
  a_flag_ext: assert property (p_flag_ext) else $error("external flag not set");

  property p_flag_pin;
    @(posedge i_sys_clk) disable iff (i_sys_rst) pin_event |=> interrupt_control_q[0];
  endproperty
  a_flag_pin: assert property (p_flag_pin) else $error("pin change flag not set");

  property p_gie_block;
    @(posedge i_sys_clk) disable iff (i_sys_rst) !interrupt_control_q[7] |=> !o_irq_request;
  endproperty
  a_gie_block: assert property (p_gie_block) else $error("request with global enable clear");

  property p_irq_tmr;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (interrupt_control_q[7] && interrupt_control_q[5] && interrupt_control_q[2]) |=> o_irq_request;
  endproperty
  a_irq_tmr: assert property (p_irq_tmr) else $error("enabled timer0 flag not requested");

  property p_pullup_off;
    @(posedge i_sys_clk) disable iff (i_sys_rst) option_config_q[7] |=> (o_pullup_on == '0);
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up on while disabled");

  property p_bor_hidden;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (!i_brown_out_enable && rd_access && i_paddr == core_regs_pkg::OFS_RESET_CAUSE_STATUS) |=> !o_prdata[0];
  endproperty
  a_bor_hidden: assert property (p_bor_hidden) else $error("brown-out bit visible while disabled");

  property p_por_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst) i_power_on_reset |=> !reset_cause_q[1];
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on bit not cleared");

  property p_undivided;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (option_config_q[3] && !option_config_q[5] && !tif.count_wr) |=> (tif.count == $past(tif.count) + 8'h01);
  endproperty
  a_undivided: assert property (p_undivided) else $error("timer0 not undivided");

  c_irq: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) $rose(o_irq_request));
  c_pin: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) pin_event);
  c_ovf: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst) tif.overflow);
endmodule

// ===== core_regs_pkg.sv
// package: register map, fields, reset values and timing for the core control registers
package core_regs_pkg;

  // register byte offsets (chosen)
  localparam logic [7:0] OFS_OPTION_CONFIG = 8'h00;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h04;
  localparam logic [7:0] OFS_RESET_CAUSE_STATUS = 8'h08;
  localparam logic [7:0] OFS_PIN_CHANGE_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_PULLUP_ENABLE = 8'h10;
  localparam logic [7:0] OFS_TIMER0_COUNT = 8'h14;

  // option_config fields
  localparam int OPT_PULLUP_GLOBAL_DISABLE = 7;
  localparam int OPT_EXT_IRQ_EDGE_SEL = 6;
  localparam int OPT_TIMER0_SOURCE_SEL = 5;
  localparam int OPT_TIMER0_EDGE_SEL = 4;
  localparam int OPT_PRESCALER_ASSIGN = 3;
  localparam int OPT_PRESCALER_RATE_LSB = 0;

  // interrupt_control fields
  localparam int IC_GLOBAL_IRQ_ENABLE = 7;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int IC_TIMER0_OVERFLOW_IRQ_ENABLE = 5;
  localparam int IC_EXT_PIN_IRQ_ENABLE = 4;
  localparam int IC_PIN_CHANGE_IRQ_ENABLE = 3;
  localparam int IC_TIMER0_OVERFLOW_FLAG = 2;
  localparam int IC_EXT_PIN_IRQ_FLAG = 1;
  localparam int IC_PIN_CHANGE_FLAG = 0;

  // reset_cause_status fields
  localparam int RCS_POWER_ON = 1;
  localparam int RCS_BROWN_OUT = 0;

  // reset values
  localparam logic [7:0] RST_OPTION_CONFIG = 8'hFF;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PIN_CHANGE_ENABLE = 8'h00;
  localparam logic [7:0] RST_PULLUP_ENABLE = 8'h3F;
  localparam logic [1:0] RST_RESET_CAUSE_STATUS = 2'h3;

  // port width and prescaler depth
  localparam int PORT_PINS = 6;
  localparam int PRESCALE_BITS = 8;

  // clock
  localparam int CLK_PERIOD_NS = 40;

endpackage

// ===== edge_detect.sv
// edge detector for the external interrupt pin and the port pins
`timescale 1ns/10ps
module edge_detect #(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // sampled levels
  input wire logic [WIDTH-1:0] i_level,
  // edge pulses
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] last_q;
  logic primed_q;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("edge_detect: WIDTH must be at least 1");
    end
  end

  // first sample after reset only primes the history
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      last_q <= '0;
      primed_q <= 1'b0;
    end
    else
    begin
      last_q <= i_level;
      primed_q <= 1'b1;
    end
  end

  assign o_rise = primed_q ? (i_level & ~last_q) : '0;
  assign o_fall = primed_q ? (~i_level & last_q) : '0;
endmodule

// ===== test_core_option_interrupt_reset_regs.sv
// testbench for the core option, interrupt and reset cause registers
`timescale 1ns/10ps
module test_core_option_interrupt_reset_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0;
  logic bor = 1'b0;
  logic bor_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_pin = 1'b0;
  logic t0_pin = 1'b0;
  logic [5:0] port = 6'h00;
  logic per_irq = 1'b0;
  logic irq;
  logic [5:0] pullup_on;
  logic wdt_tick;
  logic [31:0] rd;
  logic err;
  int err_count = 0;
  int num_checks = 0;

  always #20 clk = ~clk;

  core_option_interrupt_reset_regs DUT
  (
    .i_sys_clk(clk),
    .i_sys_rst(rst),
    .i_power_on_reset(por),
    .i_brown_out_reset(bor),
    .i_brown_out_enable(bor_en),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_ext_irq_pin(ext_pin),
    .i_timer0_clock_pin(t0_pin),
    .i_port_pins(port),
    .i_peripheral_irq(per_irq),
    .o_irq_request(irq),
    .o_pullup_on(pullup_on),
    .o_wdt_tick(wdt_tick)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] act);
    num_checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, act);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(name, {24'h000000, exp}, rd);
  endtask

  task t0_rise;
    t0_pin <= 1'b1;
    cyc(4);
    t0_pin <= 1'b0;
    cyc(4);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    check("pullup_on", 32'h0, {26'h0, pullup_on});
    rdchk("option", core_regs_pkg::OFS_OPTION_CONFIG, 8'hFF);
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    rdchk("pce", core_regs_pkg::OFS_PIN_CHANGE_ENABLE, 8'h00);
    rdchk("pue", core_regs_pkg::OFS_PULLUP_ENABLE, 8'h3F);
    rdchk("unmapped", 8'h18, 8'h00);
    check("pslverr", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask

  task t_pullup;
    wr(core_regs_pkg::OFS_OPTION_CONFIG, 8'h7F);
    wr(core_regs_pkg::OFS_PULLUP_ENABLE, 8'h05);
    cyc(2);
    check("pullup_on", 32'h05, {26'h0, pullup_on});
    $display("test pullup done");
  endtask

  task t_ext;
    ext_pin <= 1'b1;
    cyc(3);
    check("irq", 32'h0, {31'h0, irq});
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h02);
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    ext_pin <= 1'b0;
    cyc(3);
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    wr(core_regs_pkg::OFS_OPTION_CONFIG, 8'h3F);
    ext_pin <= 1'b1;
    cyc(3);
    ext_pin <= 1'b0;
    cyc(3);
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h02);
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h92);
    cyc(3);
    check("irq", 32'h1, {31'h0, irq});
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h12);
    cyc(3);
    check("irq", 32'h0, {31'h0, irq});
    $display("test ext done");
  endtask

  task t_pinchg;
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    wr(core_regs_pkg::OFS_PIN_CHANGE_ENABLE, 8'h04);
    port <= 6'h08;
    cyc(3);
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    port <= 6'h0C;
    cyc(3);
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h01);
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h89);
    cyc(3);
    check("irq", 32'h1, {31'h0, irq});
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    $display("test pin change done");
  endtask

  task t_timer;
    wr(core_regs_pkg::OFS_OPTION_CONFIG, 8'h28);
    wr(core_regs_pkg::OFS_TIMER0_COUNT, 8'hFE);
    t0_rise();
    rdchk("count", core_regs_pkg::OFS_TIMER0_COUNT, 8'hFF);
    t0_rise();
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h04);
    rdchk("count", core_regs_pkg::OFS_TIMER0_COUNT, 8'h00);
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'hA4);
    cyc(2);
    check("irq", 32'h1, {31'h0, irq});
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    wr(core_regs_pkg::OFS_OPTION_CONFIG, 8'h20);
    wr(core_regs_pkg::OFS_TIMER0_COUNT, 8'h10);
    t0_rise();
    t0_rise();
    rdchk("count", core_regs_pkg::OFS_TIMER0_COUNT, 8'h11);
    wr(core_regs_pkg::OFS_OPTION_CONFIG, 8'h38);
    wr(core_regs_pkg::OFS_TIMER0_COUNT, 8'h20);
    t0_pin <= 1'b1;
    cyc(4);
    rdchk("count", core_regs_pkg::OFS_TIMER0_COUNT, 8'h20);
    t0_pin <= 1'b0;
    cyc(4);
    rdchk("count", core_regs_pkg::OFS_TIMER0_COUNT, 8'h21);
    $display("test timer done");
  endtask

  task t_wdt(input logic [7:0] opt, input int exp);
    int n;
    wr(core_regs_pkg::OFS_OPTION_CONFIG, opt);
    cyc(4);
    n = 0;
    repeat (32)
    begin
      @(posedge clk);
      if (wdt_tick === 1'b1)
        n++;
    end
    check("wdt_ticks", exp, n);
    $display("test watchdog done");
  endtask

  task t_cause;
    por <= 1'b1;
    cyc(1);
    por <= 1'b0;
    rdchk("cause", core_regs_pkg::OFS_RESET_CAUSE_STATUS, 8'h01);
    wr(core_regs_pkg::OFS_RESET_CAUSE_STATUS, 8'h03);
    bor <= 1'b1;
    cyc(1);
    bor <= 1'b0;
    rdchk("cause", core_regs_pkg::OFS_RESET_CAUSE_STATUS, 8'h02);
    wr(core_regs_pkg::OFS_RESET_CAUSE_STATUS, 8'h03);
    rdchk("cause", core_regs_pkg::OFS_RESET_CAUSE_STATUS, 8'h03);
    bor_en <= 1'b0;
    rdchk("cause", core_regs_pkg::OFS_RESET_CAUSE_STATUS, 8'h02);
    $display("test reset cause done");
  endtask

  task t_periph;
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'hC0);
    per_irq <= 1'b1;
    cyc(3);
    check("irq", 32'h1, {31'h0, irq});
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h80);
    cyc(3);
    check("irq", 32'h0, {31'h0, irq});
    per_irq <= 1'b0;
    $display("test peripheral done");
  endtask

  task t_midreset;
    wr(core_regs_pkg::OFS_OPTION_CONFIG, 8'h28);
    wr(core_regs_pkg::OFS_TIMER0_COUNT, 8'h5A);
    wr(core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'hF8);
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    check("pullup_on", 32'h0, {26'h0, pullup_on});
    check("irq", 32'h0, {31'h0, irq});
    rdchk("count", core_regs_pkg::OFS_TIMER0_COUNT, 8'h5A);
    rdchk("option", core_regs_pkg::OFS_OPTION_CONFIG, 8'hFF);
    rdchk("intctl", core_regs_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    rdchk("cause", core_regs_pkg::OFS_RESET_CAUSE_STATUS, 8'h02);
    $display("test mid-run reset done");
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pullup();
    t_ext();
    t_pinchg();
    t_timer();
    t_wdt(8'h0A, 8);
    t_wdt(8'h02, 0);
    t_cause();
    t_periph();
    t_midreset();
    print_verdict();
  end
endmodule

// ===== timer0_if.sv
// interface: timer0 configuration and count events between top and timer0 unit
`timescale 1ns/10ps
interface timer0_if;
  logic source_sel;
  logic edge_sel;
  logic prescaler_assign;
  logic [2:0] prescaler_rate;
  logic count_wr;
  logic [7:0] count_wdata;
  logic [7:0] count;
  logic overflow;
  logic wdt_tick;

  modport ctrl
  (
    output source_sel, edge_sel, prescaler_assign, prescaler_rate, count_wr, count_wdata,
    input count, overflow, wdt_tick
  );
  modport unit
  (
    input source_sel, edge_sel, prescaler_assign, prescaler_rate, count_wr, count_wdata,
    output count, overflow, wdt_tick
  );
endinterface

// ===== timer0_unit.sv
// timer0 counter with the shared timer0/watchdog prescaler
`timescale 1ns/10ps
module timer0_unit
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // timer clock pin
  input wire logic i_timer0_clock_pin,
  // control and status
  timer0_if.unit tif
);
  logic pin_last_q;
  logic pin_edge;
  logic tick_src;
  logic [core_regs_pkg::PRESCALE_BITS-1:0] pre_q;
  logic [core_regs_pkg::PRESCALE_BITS-1:0] pre_d;
  logic pre_out;
  logic tmr_tick;
  logic [7:0] count_q;

  // tap mask: bits below the selected ratio must all be ones at the wrap
  function automatic logic [core_regs_pkg::PRESCALE_BITS-1:0] tap_mask(input logic [3:0] n);
    tap_mask = 8'((9'h001 << n) - 9'h001);
  endfunction

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pin_last_q <= 1'b0;
    end
    else
    begin
      pin_last_q <= i_timer0_clock_pin;
    end
  end

  // falling edge when edge select is 1, rising when 0
  assign pin_edge = tif.edge_sel ? (pin_last_q & ~i_timer0_clock_pin) : (~pin_last_q & i_timer0_clock_pin);
  // pin transitions or the instruction clock
  assign tick_src = tif.source_sel ? pin_edge : 1'b1;

  // timer0 ratio 2^(rate+1), watchdog ratio 2^rate
  always_comb
  begin
    pre_d = pre_q + 8'h01;
    if (tif.prescaler_assign)
    begin
      pre_out = ((pre_q & tap_mask({1'b0, tif.prescaler_rate})) == tap_mask({1'b0, tif.prescaler_rate}));
    end
    else
    begin
      pre_out = ((pre_q & tap_mask({1'b0, tif.prescaler_rate} + 4'h1)) ==
        tap_mask({1'b0, tif.prescaler_rate} + 4'h1));
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pre_q <= '0;
    end
    else if (tif.prescaler_assign || tick_src)
    begin
      pre_q <= pre_d;
    end
  end

  // prescaler to watchdog: timer0 runs undivided
  assign tmr_tick = tif.prescaler_assign ? tick_src : (tick_src & pre_out);
  assign tif.wdt_tick = tif.prescaler_assign & pre_out;

  // count has no reset, it holds its value across reset
  always_ff @(posedge i_sys_clk)
  begin
    if (tif.count_wr)
    begin
      count_q <= tif.count_wdata;
    end
    else if (tmr_tick)
    begin
      count_q <= count_q + 8'h01;
    end
  end

  assign tif.count = count_q;
  assign tif.overflow = tmr_tick && !tif.count_wr && (count_q == 8'hFF);
endmodule
